/* verilog/gpr_pkg.sv */
// package for the general i/o pin resource router: map, fields, resets, types
package gpr_pkg;

    // special-function register offsets
    localparam logic [7:0] SFR_PORT0_DATA = 8'h80;
    localparam logic [7:0] SFR_PORT0_DIR = 8'ha2;
    localparam logic [7:0] SFR_PORT1_DATA = 8'h90;
    localparam logic [7:0] SFR_PORT1_DIR = 8'h91;
    localparam logic [7:0] SFR_PORT2_DATA = 8'ha0;
    localparam logic [7:0] SFR_PORT2_DIR = 8'ha1;

    // i/o ram offsets
    localparam logic [15:0] IO_RSEL_FIRST = 16'h2009;
    localparam logic [15:0] IO_RSEL_LAST = 16'h200e;
    localparam logic [15:0] IO_PIN_CTRL = 16'h2010;
    localparam logic [15:0] IO_SEG_COUNT = 16'h2011;

    // field positions
    localparam int RSEL_W = 3;
    localparam int RSEL_LO_POS = 0;
    localparam int RSEL_HI_POS = 4;
    localparam int CTRL_W = 5;
    localparam int CTRL_PW_BIT = 0;
    localparam int CTRL_PV_BIT = 1;
    localparam int CTRL_UART_BIT = 2;
    localparam int CTRL_EE2_BIT = 3;
    localparam int CTRL_EE3_BIT = 4;
    localparam int SEG_W = 5;

    // pin roles and pin sets
    localparam int PIN_N = 24;
    localparam int PIN_OPT_TX = 1;
    localparam int PIN_OPT_RX = 2;
    localparam int PIN_EE_SCK = 4;
    localparam int PIN_EE_SDA = 5;
    localparam int PIN_PULSE_ACT = 6;
    localparam int PIN_PULSE_REACT = 7;
    localparam logic [23:0] PIN_EXIST = 24'h3bcffe;
    localparam logic [23:0] PIN_DUAL = 24'h3bcff0;
    localparam logic [23:0] PIN_ROUTABLE = 24'h000ffe;

    // reset values
    localparam logic [23:0] RST_DATA = 24'h000000;
    localparam logic [23:0] RST_DIR = 24'h000000;
    localparam logic [35:0] RST_RSEL = 36'h000000000;
    localparam logic [4:0] RST_CTRL = 5'h00;
    localparam logic [4:0] RST_SEG = 5'h00;

    // three-wire serial clock timing
    localparam int CLK_KHZ = 100000;
    localparam int EE3_KHZ = 500;
    localparam int EE3_HALF_CYC = CLK_KHZ / (2 * EE3_KHZ);

    typedef enum logic [2:0] {
        RS_NONE = 3'h0, RS_RSVD = 3'h1, RS_CNT0 = 3'h2, RS_CNT1 = 3'h3,
        RS_HI_RISE = 3'h4, RS_LO_RISE = 3'h5, RS_HI_FALL = 3'h6, RS_LO_FALL = 3'h7
    } gpr_rsel_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gpr_sfr_req_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } gpr_io_req_t;

    typedef struct packed {
        logic ce_active_pulse;
        logic ce_reactive_pulse;
        logic optical_tx;
        logic ee_scl_out;
        logic ee_sda_out;
        logic ee_sda_oe;
    } gpr_alt_in_t;

    typedef struct packed {
        logic [23:0] data;
        logic [23:0] dir;
        logic [35:0] rsel;
        logic [4:0] ctrl;
        logic [4:0] seg_count;
        logic [23:0] sync1;
        logic [23:0] sync2;
        logic [23:0] prev;
        logic [23:0] pin_out;
        logic [23:0] pin_oe;
        logic cnt0;
        logic cnt1;
        logic irq_hi;
        logic irq_lo;
        logic uart_rx;
        logic sda_in;
        logic [7:0] sfr_rdata;
        logic [7:0] io_rdata;
        logic [7:0] div;
        logic sck;
    } gpr_state_t;

    localparam gpr_state_t ST_RESET = '{data: RST_DATA, dir: RST_DIR, rsel: RST_RSEL,
        ctrl: RST_CTRL, seg_count: RST_SEG, default: '0};

    // rank of a pin among the dual-function pins, lowest pin first
    function automatic int dual_rank(input int pin);
        int r;
        r = 0;
        for (int k = 0; k < pin; k++) begin
            if (PIN_DUAL[k]) r++;
        end
        return r;
    endfunction : dual_rank

endpackage : gpr_pkg

/* verilog/gpr_general_io_pin_resource_router.sv */
// general i/o port with per-pin direction, data, resource routing and pin sharing
// Operation
// [RL1] all pins are inputs after reset
// [RL2] direction bit: 0 input, 1 output
// [RL3] each eligible pin has 3-bit resource select
// [RL4] 0 none, 1 reserved, 2/3 counter clocks
// [RL5] 4/5 rising, 6/7 falling edge interrupts
// [RL6] shared resource sees OR of pins
// [RL7] routing follows pin level when output
// [RL8] routing only pins 1-11 as general i/o
// [RL9] port data/direction at 0x90/0x91, 0xa0/0xa1
// [RL10] select words at 0x2009 through 0x200e
// [RL11] pins 6/7 carry energy pulses when routed
// [RL12] optical uart pins free as pins 1/2
// [RL13] segment count claims dual-function pins
// [RL14] two-pin eeprom: pin 4 clock, 5 data
// [RL15] three-wire eeprom clock at 500 khz
// [RL16] data write drives pin, read gives level
`timescale 1ns/1ps
module gpr_general_io_pin_resource_router
    import gpr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input gpr_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    input gpr_io_req_t io_req,
    output logic [7:0] io_rdata,
    input wire logic [23:0] pin_in,
    output logic [23:0] pin_out,
    output logic [23:0] pin_oe,
    input gpr_alt_in_t alt_in,
    output logic optical_rx_level,
    output logic eeprom_serial_data_in,
    output logic counter0_clock_input,
    output logic counter1_clock_input,
    output logic high_prio_ext_irq,
    output logic low_prio_ext_irq
);

    gpr_state_t st_r;
    gpr_state_t st_nxt;

    logic [23:0] is_gpio;
    logic [23:0] hit_t0;
    logic [23:0] hit_t1;
    logic [23:0] hit_hi;
    logic [23:0] hit_lo;
    logic [23:0] drv_out;
    logic [23:0] drv_oe;
    logic [23:0] rise;
    logic [23:0] fall;
    logic [23:0] level;
    logic uart_en;
    logic pw_on;
    logic pv_on;
    logic two_wire;
    logic three_wire;
    logic rs_hit;
    logic [2:0] rs_idx;

    // mode decode from the pin control register
    assign uart_en = st_r.ctrl[CTRL_UART_BIT];
    assign pw_on = st_r.ctrl[CTRL_PW_BIT];
    assign pv_on = st_r.ctrl[CTRL_PV_BIT];
    assign three_wire = st_r.ctrl[CTRL_EE3_BIT];
    assign two_wire = st_r.ctrl[CTRL_EE2_BIT] && !three_wire;

    // synchronised pin level and its edges
    assign level = st_r.sync2;
    assign rise = st_r.sync2 & ~st_r.prev;
    assign fall = ~st_r.sync2 & st_r.prev;

    // select word index within the i/o ram window, two fields per byte
    assign rs_hit = (io_req.addr >= IO_RSEL_FIRST) && (io_req.addr <= IO_RSEL_LAST);
    assign rs_idx = 3'(io_req.addr - IO_RSEL_FIRST);

    // per-pin ownership, resource routing and pad drive
    for (genvar i = 0; i < PIN_N; i++) begin : g_pin
        logic seg;
        logic uart_pin;
        logic o;
        logic e;

        // dual-function pins are taken as segments from the lowest up
        assign seg = PIN_DUAL[i] && (SEG_W'(dual_rank(i)) < st_r.seg_count); // [RL13]
        assign uart_pin = uart_en && (i == PIN_OPT_TX || i == PIN_OPT_RX); // [RL12]
        assign is_gpio[i] = PIN_EXIST[i] && !seg && !uart_pin;

        if (PIN_ROUTABLE[i]) begin : g_rt
            gpr_rsel_t sel;
            // level is the pad itself, so driven outputs are tracked too
            assign sel = gpr_rsel_t'(st_r.rsel[i*RSEL_W +: RSEL_W]); // [RL3] [RL10]
            assign hit_t0[i] = is_gpio[i] && sel == RS_CNT0 && level[i]; // [RL4] [RL7] [RL8]
            assign hit_t1[i] = is_gpio[i] && sel == RS_CNT1 && level[i]; // [RL4] [RL7] [RL8]
            assign hit_hi[i] = is_gpio[i] && ((sel == RS_HI_RISE && rise[i])
                || (sel == RS_HI_FALL && fall[i])); // [RL5] [RL8]
            assign hit_lo[i] = is_gpio[i] && ((sel == RS_LO_RISE && rise[i])
                || (sel == RS_LO_FALL && fall[i])); // [RL5] [RL8]
        end else begin : g_nr
            assign hit_t0[i] = 1'b0; // [RL8]
            assign hit_t1[i] = 1'b0;
            assign hit_hi[i] = 1'b0;
            assign hit_lo[i] = 1'b0;
        end

        // pad drive: port by default, alternate functions take over
        always_comb begin
            o = st_r.data[i]; // [RL16]
            e = is_gpio[i] && st_r.dir[i]; // [RL1] [RL2]
            if (uart_pin) begin
                o = (i == PIN_OPT_TX) ? alt_in.optical_tx : 1'b0; // [RL12]
                e = (i == PIN_OPT_TX);
            end else if (i == PIN_PULSE_ACT && is_gpio[i] && st_r.dir[i] && pw_on) begin
                o = alt_in.ce_active_pulse; // [RL11]
            end else if (i == PIN_PULSE_REACT && is_gpio[i] && st_r.dir[i] && pv_on) begin
                o = alt_in.ce_reactive_pulse; // [RL11]
            end else if (i == PIN_EE_SCK && (two_wire || three_wire)) begin
                o = three_wire ? st_r.sck : alt_in.ee_scl_out; // [RL14] [RL15]
                e = 1'b1;
            end else if (i == PIN_EE_SDA && (two_wire || three_wire)) begin
                o = alt_in.ee_sda_out; // [RL14]
                e = alt_in.ee_sda_oe;
            end
        end

        assign drv_out[i] = o;
        assign drv_oe[i] = e;
    end

    // next state: synchronisers, outputs, divider and register access
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1 = pin_in;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.prev = st_r.sync2;
        st_nxt.pin_out = drv_out;
        st_nxt.pin_oe = drv_oe;
        st_nxt.cnt0 = |hit_t0; // [RL6]
        st_nxt.cnt1 = |hit_t1; // [RL6]
        st_nxt.irq_hi = |hit_hi; // [RL6]
        st_nxt.irq_lo = |hit_lo; // [RL6]
        st_nxt.uart_rx = uart_en ? level[PIN_OPT_RX] : 1'b1; // [RL12]
        st_nxt.sda_in = level[PIN_EE_SDA];

        // three-wire serial clock: toggle every half period
        if (three_wire) begin
            if (st_r.div == 8'(EE3_HALF_CYC - 1)) begin
                st_nxt.div = 8'h00;
                st_nxt.sck = !st_r.sck; // [RL15]
            end else begin
                st_nxt.div = st_r.div + 8'h01;
            end
        end else begin
            st_nxt.div = 8'h00;
            st_nxt.sck = 1'b0;
        end

        // special-function register writes
        if (sfr_req.wr) begin
            case (sfr_req.addr)
                SFR_PORT0_DATA: st_nxt.data[7:0] = sfr_req.wdata;
                SFR_PORT0_DIR: st_nxt.dir[7:0] = sfr_req.wdata;
                SFR_PORT1_DATA: st_nxt.data[15:8] = sfr_req.wdata; // [RL9] [RL16]
                SFR_PORT1_DIR: st_nxt.dir[15:8] = sfr_req.wdata; // [RL9] [RL2]
                SFR_PORT2_DATA: st_nxt.data[23:16] = sfr_req.wdata; // [RL9]
                SFR_PORT2_DIR: st_nxt.dir[23:16] = sfr_req.wdata; // [RL9]
                default: st_nxt.data = st_r.data;
            endcase
        end

        // special-function register reads: data ports return the pad level
        st_nxt.sfr_rdata = 8'h00;
        if (sfr_req.rd) begin
            case (sfr_req.addr)
                SFR_PORT0_DATA: st_nxt.sfr_rdata = level[7:0] & PIN_EXIST[7:0]; // [RL16]
                SFR_PORT0_DIR: st_nxt.sfr_rdata = st_r.dir[7:0] & PIN_EXIST[7:0];
                SFR_PORT1_DATA: st_nxt.sfr_rdata = level[15:8] & PIN_EXIST[15:8]; // [RL16]
                SFR_PORT1_DIR: st_nxt.sfr_rdata = st_r.dir[15:8] & PIN_EXIST[15:8]; // [RL2]
                SFR_PORT2_DATA: st_nxt.sfr_rdata = level[23:16] & PIN_EXIST[23:16];
                SFR_PORT2_DIR: st_nxt.sfr_rdata = st_r.dir[23:16] & PIN_EXIST[23:16]; // [RL9]
                default: st_nxt.sfr_rdata = 8'h00;
            endcase
        end

        // i/o ram writes: select words, pin control, segment count
        if (io_req.wr) begin
            if (rs_hit) begin
                st_nxt.rsel[rs_idx*6 +: RSEL_W] = io_req.wdata[RSEL_LO_POS +: RSEL_W]; // [RL10]
                st_nxt.rsel[rs_idx*6+3 +: RSEL_W] = io_req.wdata[RSEL_HI_POS +: RSEL_W];
            end else if (io_req.addr == IO_PIN_CTRL) begin
                st_nxt.ctrl = io_req.wdata[CTRL_W-1:0];
            end else if (io_req.addr == IO_SEG_COUNT) begin
                st_nxt.seg_count = io_req.wdata[SEG_W-1:0]; // [RL13]
            end
        end

        // i/o ram reads, unused bits read as zero
        st_nxt.io_rdata = 8'h00;
        if (io_req.rd) begin
            if (rs_hit) begin
                st_nxt.io_rdata[RSEL_LO_POS +: RSEL_W] = st_r.rsel[rs_idx*6 +: RSEL_W];
                st_nxt.io_rdata[RSEL_HI_POS +: RSEL_W] = st_r.rsel[rs_idx*6+3 +: RSEL_W];
            end else if (io_req.addr == IO_PIN_CTRL) begin
                st_nxt.io_rdata[CTRL_W-1:0] = st_r.ctrl;
            end else if (io_req.addr == IO_SEG_COUNT) begin
                st_nxt.io_rdata[SEG_W-1:0] = st_r.seg_count;
            end
        end
    end

    // single state register; reset leaves every pin an input
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= ST_RESET; // [RL1]
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign pin_out = st_r.pin_out;
    assign pin_oe = st_r.pin_oe;
    assign sfr_rdata = st_r.sfr_rdata;
    assign io_rdata = st_r.io_rdata;
    assign optical_rx_level = st_r.uart_rx;
    assign eeprom_serial_data_in = st_r.sda_in;
    assign counter0_clock_input = st_r.cnt0;
    assign counter1_clock_input = st_r.cnt1;
    assign high_prio_ext_irq = st_r.irq_hi;
    assign low_prio_ext_irq = st_r.irq_lo;

    // no pin is driven in the first cycle after reset release
    a_reset_all_inputs: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(reset_n) |-> pin_oe == 24'h000000) // [RL1]
        else $error("pin driven right after reset");

    // dedicated pin 3 enable follows its direction bit one cycle later
    a_dir_sets_enable: assert property (@(posedge clk_sys) disable iff (!reset_n)
        is_gpio[3] |=> pin_oe[3] == $past(st_r.dir[3])) // [RL2]
        else $error("pin 3 enable does not follow direction");

    // select 2 on pin 3 with high level yields counter 0 clock
    a_cnt0_route: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (is_gpio[3] && st_r.rsel[9 +: 3] == RS_CNT0 && level[3]) |=> counter0_clock_input) // [RL4]
        else $error("counter 0 clock not routed");

    // reserved or none codes route nothing from pin 1
    a_none_routes_nil: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (st_r.rsel[5:3] inside {RS_NONE, RS_RSVD}) |-> !(hit_t0[1] || hit_t1[1]
        || hit_hi[1] || hit_lo[1])) // [RL4]
        else $error("none or reserved code routed");

    // a rising edge on a select-4 pin fires the high interrupt
    a_hi_rise_irq: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (is_gpio[8] && st_r.rsel[24 +: 3] == RS_HI_RISE && rise[8]) |=> high_prio_ext_irq) // [RL5]
        else $error("rising edge interrupt missed");

    // the low interrupt pulse always has a falling or rising cause
    a_lo_irq_cause: assert property (@(posedge clk_sys) disable iff (!reset_n)
        low_prio_ext_irq |-> $past(|hit_lo)) // [RL5] [RL6]
        else $error("low interrupt without a cause");

    // counter 1 clock is the or of every pin that selects it
    a_or_combine: assert property (@(posedge clk_sys) disable iff (!reset_n)
        1'b1 |=> counter1_clock_input == $past(|hit_t1)) // [RL6]
        else $error("counter 1 clock is not the or of its pins");

    // an output pin still feeds its resource from the pad level
    a_output_tracked: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (st_r.dir[9] && is_gpio[9] && st_r.rsel[27 +: 3] == RS_CNT1 && level[9])
        |=> counter1_clock_input) // [RL7]
        else $error("output pin not tracked");

    // the upper port never reaches a resource
    a_upper_unrouted: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (hit_t0[23:12] | hit_t1[23:12] | hit_hi[23:12] | hit_lo[23:12]) == 12'h000) // [RL8]
        else $error("pin outside 1 to 11 routed");

    // port one data read returns the pad level
    a_port_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (sfr_req.rd && sfr_req.addr == SFR_PORT1_DATA)
        |=> sfr_rdata == ($past(level[15:8]) & PIN_EXIST[15:8])) // [RL9] [RL16]
        else $error("port one read wrong");

    // active pulse output carries the compute engine pulse
    a_pulse_out: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (pw_on && st_r.dir[6] && is_gpio[6]) |=> pin_out[6] == $past(alt_in.ce_active_pulse)
        && pin_oe[6]) // [RL11]
        else $error("active pulse not on pin 6");

    // optical uart owns pins 1 and 2 while enabled
    a_uart_pins: assert property (@(posedge clk_sys) disable iff (!reset_n)
        uart_en |=> !pin_oe[2] && pin_oe[1] && pin_out[1] == $past(alt_in.optical_tx)) // [RL12]
        else $error("optical pins not handed over");

    // two-pin eeprom clock appears on pin 4
    a_eeprom_clock: assert property (@(posedge clk_sys) disable iff (!reset_n)
        two_wire |=> pin_oe[4] && pin_out[4] == $past(alt_in.ee_scl_out)) // [RL14]
        else $error("eeprom clock not on pin 4");

    // three-wire clock toggles when the divider reaches the end of the half period
    a_sck_period: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (three_wire && st_r.div == 8'(EE3_HALF_CYC - 1)) |=> st_r.sck != $past(st_r.sck)) // [RL15]
        else $error("three-wire clock period wrong");

endmodule : gpr_general_io_pin_resource_router

/* sim/gpr_pad_model.sv */
// pad-side model: switches drive released pads, driven pads read back their own level
`timescale 1ns/1ps
module gpr_pad_model (
    input wire logic [23:0] pin_out,
    input wire logic [23:0] pin_oe,
    input wire logic [23:0] ext_lvl,
    output logic [23:0] pin_in
);
    // a driven pad shows its own output, so routing can track it
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : gpr_pad_model

/* sim/gpr_general_io_pin_resource_router_tb.sv */
// self-checking bench for the general i/o pin resource router
`timescale 1ns/1ps
module gpr_general_io_pin_resource_router_tb import gpr_pkg::*;;
    localparam logic IO = 1'b1;
    localparam logic SF = 1'b0;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    gpr_sfr_req_t sfr_req = '0;
    gpr_io_req_t io_req = '0;
    gpr_alt_in_t alt_in = '0;
    logic [23:0] ext_lvl = '0;
    logic [23:0] pin_in;
    logic [23:0] pin_out;
    logic [23:0] pin_oe;
    logic [7:0] sfr_rdata;
    logic [7:0] io_rdata;
    logic rx_lvl, sda_in, cnt0, cnt1, irq_hi, irq_lo;
    int num_errors = 0;
    int checks_done = 0;
    int n_hi, n_lo, n_c0, n_c1;

    // 100 mhz system clock
    always #5 clk_sys = ~clk_sys;

    gpr_general_io_pin_resource_router dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .io_req(io_req), .io_rdata(io_rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .alt_in(alt_in), .optical_rx_level(rx_lvl),
        .eeprom_serial_data_in(sda_in), .counter0_clock_input(cnt0),
        .counter1_clock_input(cnt1), .high_prio_ext_irq(irq_hi), .low_prio_ext_irq(irq_lo)
    );

    gpr_pad_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));

    // report, verdict and stop
    task automatic end_sim;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [23:0] e, input logic [23:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // one-cycle write strobe, launched on the falling edge
    task automatic wr(input logic io, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        if (io) io_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        else sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a[7:0], wdata: d};
        @(negedge clk_sys);
        io_req = '0;
        sfr_req = '0;
    endtask : wr

    // read data stands for the cycle after the taking edge
    task automatic rchk(input string what, input logic io, input logic [15:0] a,
                        input logic [7:0] e);
        @(negedge clk_sys);
        if (io) io_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        else sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a[7:0], wdata: 8'h00};
        @(negedge clk_sys);
        io_req = '0;
        sfr_req = '0;
        chk(what, 24'(e), 24'(io ? io_rdata : sfr_rdata));
    endtask : rchk

    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : idle

    // count interrupt pulses and counter-clock high cycles
    task automatic obs(input int n);
        n_hi = 0;
        n_lo = 0;
        n_c0 = 0;
        n_c1 = 0;
        repeat (n) begin
            @(negedge clk_sys);
            if (irq_hi === 1'b1) n_hi++;
            if (irq_lo === 1'b1) n_lo++;
            if (cnt0 === 1'b1) n_c0++;
            if (cnt1 === 1'b1) n_c1++;
        end
    endtask : obs

    // cycles until the serial clock pad changes, bounded
    task automatic sck_edge(output int n);
        logic v;
        v = pin_out[4];
        n = 0;
        while (pin_out[4] === v) begin
            @(negedge clk_sys);
            n++;
            if (n > 300) begin
                num_errors++;
                $display("Error sck expected toggle seen none");
                end_sim();
            end
        end
    endtask : sck_edge

    // main sequence
    initial begin
        int n;
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        reset_n = 1'b1;
        idle(2);
        chk("oe reset", 24'h000000, pin_oe);
        rchk("dir0 reset", SF, 16'h00a2, 8'h00);
        rchk("dir1 reset", SF, 16'h0091, 8'h00);
        rchk("dir2 reset", SF, 16'h00a1, 8'h00);
        // port one: pin 11 output high, pins 8 and 15 inputs held high
        ext_lvl[15:8] = 8'h81;
        wr(SF, 16'h0091, 8'h08);
        wr(SF, 16'h0090, 8'h08);
        idle(4);
        chk("oe pin11", 24'h000800, pin_oe);
        chk("out pin11", 24'h1, 24'(pin_out[11]));
        rchk("dir1", SF, 16'h0091, 8'h08);
        rchk("port1 level", SF, 16'h0090, 8'h89);
        wr(SF, 16'h0091, 8'h00);
        idle(2);
        chk("oe off", 24'h000000, pin_oe);
        // port two: nonexistent pin 18 stays clear
        wr(SF, 16'h00a1, 8'hff);
        wr(SF, 16'h00a0, 8'h05);
        idle(4);
        chk("oe port2", 24'h3b0000, pin_oe);
        rchk("dir2", SF, 16'h00a1, 8'h3b);
        rchk("port2 level", SF, 16'h00a0, 8'h01);
        wr(SF, 16'h00a1, 8'h00);
        // every select code on pin 3, rising then falling
        for (int s = 0; s < 8; s++) begin
            ext_lvl[3] = 1'b0;
            wr(IO, 16'h200a, {1'b0, 3'(s), 4'h0});
            rchk("sel pin3", IO, 16'h200a, {1'b0, 3'(s), 4'h0});
            idle(6);
            ext_lvl[3] = 1'b1;
            obs(8);
            chk("rise", 24'({2'(s == 4), 2'(s == 5), s == 2, s == 3}),
                24'({n_hi[1:0], n_lo[1:0], n_c0 != 0, n_c1 != 0}));
            ext_lvl[3] = 1'b0;
            obs(8);
            chk("fall", 24'({2'(s == 6), 2'(s == 7)}), 24'({n_hi[1:0], n_lo[1:0]}));
        end
        // pins 3 and 8 share counter 0; pin 9 on counter 1
        wr(IO, 16'h200a, 8'h20);
        wr(IO, 16'h200d, 8'h32);
        ext_lvl[8] = 1'b1;
        idle(5);
        chk("or pin8", 24'h1, 24'(cnt0));
        ext_lvl[8] = 1'b0;
        ext_lvl[3] = 1'b1;
        idle(5);
        chk("or pin3", 24'h1, 24'(cnt0));
        ext_lvl[3] = 1'b0;
        idle(5);
        chk("or none", 24'h0, 24'(cnt0));
        // driven pin 9 is still tracked by counter 1
        ext_lvl[9] = 1'b0;
        wr(SF, 16'h0091, 8'h02);
        wr(SF, 16'h0090, 8'h02);
        idle(5);
        chk("track hi", 24'h1, 24'(cnt1));
        wr(SF, 16'h0090, 8'h00);
        idle(5);
        chk("track lo", 24'h0, 24'(cnt1));
        wr(IO, 16'h200a, 8'h00);
        wr(IO, 16'h200d, 8'h00);
        // field widths and ends of the select block
        wr(IO, 16'h2009, 8'hff);
        wr(IO, 16'h200e, 8'hff);
        rchk("sel first", IO, 16'h2009, 8'h77);
        rchk("sel last", IO, 16'h200e, 8'h77);
        rchk("unmapped", IO, 16'h200f, 8'h00);
        wr(IO, 16'h2009, 8'h00);
        wr(IO, 16'h200e, 8'h00);
        // segment claim of pin 4 blocks drive and routing
        wr(IO, 16'h2011, 8'h01);
        wr(IO, 16'h200b, 8'h02);
        wr(SF, 16'h00a2, 8'h10);
        ext_lvl[4] = 1'b1;
        idle(5);
        chk("seg oe", 24'h0, 24'(pin_oe[4]));
        chk("seg route", 24'h0, 24'(cnt0));
        wr(IO, 16'h2011, 8'h00);
        wr(SF, 16'h0080, 8'h10);
        idle(5);
        chk("dio oe", 24'h1, 24'(pin_oe[4]));
        chk("dio route", 24'h1, 24'(cnt0));
        wr(IO, 16'h200b, 8'h00);
        wr(SF, 16'h0080, 8'h00);
        // energy pulse outputs on pins 6 and 7
        wr(SF, 16'h00a2, 8'hc0);
        wr(IO, 16'h2010, 8'h03);
        alt_in.ce_active_pulse = 1'b1;
        idle(3);
        chk("pulse act", 24'h1, 24'(pin_out[7:6]));
        alt_in = '{ce_reactive_pulse: 1'b1, default: 1'b0};
        idle(3);
        chk("pulse react", 24'h2, 24'(pin_out[7:6]));
        wr(IO, 16'h2010, 8'h00);
        idle(3);
        chk("pulse off", 24'h0, 24'(pin_out[7:6]));
        wr(SF, 16'h00a2, 8'h00);
        // optical uart pins
        idle(4);
        chk("rx idle", 24'h1, 24'(rx_lvl));
        wr(IO, 16'h2010, 8'h04);
        alt_in = '{optical_tx: 1'b1, default: 1'b0};
        idle(5);
        chk("uart on", 24'h6, 24'({pin_oe[2:1], pin_out[1], rx_lvl}));
        ext_lvl[2] = 1'b1;
        alt_in = '0;
        idle(5);
        chk("uart rx", 24'h5, 24'({pin_oe[2:1], pin_out[1], rx_lvl}));
        // two-pin eeprom on pins 4 and 5
        wr(IO, 16'h2010, 8'h08);
        alt_in = '{ee_scl_out: 1'b1, ee_sda_oe: 1'b1, default: 1'b0};
        idle(3);
        chk("ee drive", 24'hd, 24'({pin_oe[5:4], pin_out[5:4]}));
        alt_in.ee_sda_oe = 1'b0;
        ext_lvl[5] = 1'b1;
        idle(5);
        chk("ee read", 24'h1, 24'({pin_oe[5], sda_in}));
        // three-wire clock half period
        wr(IO, 16'h2010, 8'h10);
        sck_edge(n);
        sck_edge(n);
        chk("sck half", 24'(EE3_HALF_CYC), 24'(n));
        sck_edge(n);
        chk("sck half2", 24'(EE3_HALF_CYC), 24'(n));
        chk("sck oe", 24'h1, 24'(pin_oe[4]));
        end_sim();
    end
endmodule : gpr_general_io_pin_resource_router_tb
